// ===== bench/jtl_rx_model.sv
// Far-side receiver model: captures the physical lane words on every rising clock edge.
// Assumes the lanes are launched on core_clk_in; powered-down lanes show what they drive.
`timescale 1ns/10ps
module jtl_rx_model #(
  parameter int LANE_W = 20
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [LANE_W-1:0] lane0_in,
  input  wire logic [LANE_W-1:0] lane1_in,
  output logic      [LANE_W-1:0] rx_word0_out,
  output logic      [LANE_W-1:0] rx_word1_out
);
  // The receiver only samples; it never pushes back on the link.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_word0_out <= '0;
      rx_word1_out <= '0;
    end else begin
      rx_word0_out <= lane0_in;
      rx_word1_out <= lane1_in;
    end
  end
endmodule // jtl_rx_model

// ===== bench/testbench.sv
// Self-checking bench for the lane configuration slice, acting as AXI4-Lite master.
// Assumes the far-side receiver model and the package are compiled first.
`timescale 1ns/10ps
module testbench;
  import jtl_pkg::*;
  localparam int LW = 20;
  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [31:0]      wd;
    logic [1:0]       wr;
    logic [31:0]      rd;
    logic [1:0]       rr;
  } jtl_row_type;
  logic core_clk_in, rst_n_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, dense;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, pdown, resp;
  logic [4:0]  cwpf, sfield;
  logic [63:0] params;
  logic [4*LW-1:0] ldata;
  logic [LW-1:0] lane0, lane1, rx0, rx1;
  logic [2:0]  swing0, swing1;
  logic [5:0]  spf;
  logic [31:0] rv;
  logic [7:0]  sum;
  int fails, checked, cycles;
  jtl_row_type rows [9] = '{
    '{IDX_PWR, 32'h000000FF, RESP_OKAY, 32'h000000FF, RESP_OKAY},
    '{IDX_PWR, 32'h000000FA, RESP_OKAY, 32'h000000FA, RESP_OKAY},
    '{IDX_SEL0, 32'h000000FB, RESP_OKAY, 32'h00000073, RESP_OKAY},
    '{IDX_SEL1, 32'h00000002, RESP_OKAY, 32'h0000000A, RESP_OKAY},
    '{IDX_SWING0, 32'h000000FF, RESP_OKAY, 32'h00000007, RESP_OKAY},
    '{IDX_SWING1, 32'h00000000, RESP_OKAY, 32'h00000000, RESP_OKAY},
    '{IDX_DENSITY, 32'h00000000, RESP_OKAY, 32'h0000008A, RESP_OKAY},
    '{IDX_SAMPLES, 32'h00000000, RESP_OKAY, 32'h00000003, RESP_OKAY},
    '{14'h0600, 32'h000000FF, RESP_SLVERR, 32'h00000000, RESP_SLVERR}};
  jtl_row_type rst_rows [5] = '{
    '{IDX_PWR, 32'h0, RESP_OKAY, 32'h000000FA, RESP_OKAY},
    '{IDX_SEL0, 32'h0, RESP_OKAY, 32'h00000000, RESP_OKAY},
    '{IDX_SEL1, 32'h0, RESP_OKAY, 32'h00000019, RESP_OKAY},
    '{IDX_SWING0, 32'h0, RESP_OKAY, 32'h00000001, RESP_OKAY},
    '{IDX_SWING1, 32'h0, RESP_OKAY, 32'h00000001, RESP_OKAY}};

  jtl_lane_cfg #(.LANE_W(LW), .NUM_PBYTE(8)) i_dut (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .dense_packing_flag_in(dense),
    .ctrl_words_per_frame_in(cwpf), .samples_field_in(sfield), .link_params_in(params),
    .logical_lane_data_in(ldata), .serial_out_lane0_out(lane0), .serial_out_lane1_out(lane1),
    .lane_power_down_out(pdown), .lane0_swing_out(swing0), .lane1_swing_out(swing1),
    .samples_per_frame_out(spf));

  jtl_rx_model #(.LANE_W(LW)) i_rx (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .lane0_in(lane0), .lane1_in(lane1),
    .rx_word0_out(rx0), .rx_word1_out(rx1));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // Readies are looked at on the falling edge, so the rising edge that follows is the handshake.
  task automatic axi_wr(input logic [IDX_W-1:0] idx, input logic [31:0] d, output logic [1:0] r,
                        input logic [3:0] s = 4'hF);
    bit a_done, w_done, a_hit, w_hit;
    awaddr <= {idx, 2'h0};
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    a_done = 0;
    w_done = 0;
    while (!(a_done && w_done)) begin
      @(negedge core_clk_in);
      a_hit = awvalid && awready;
      w_hit = wvalid && wready;
      @(posedge core_clk_in);
      if (a_hit) begin
        awvalid <= 1'b0;
        a_done = 1;
      end
      if (w_hit) begin
        wvalid <= 1'b0;
        w_done = 1;
      end
    end
    bready <= 1'b1;
    do @(negedge core_clk_in); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge core_clk_in);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [IDX_W-1:0] idx, output logic [31:0] d, output logic [1:0] r);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    do @(negedge core_clk_in); while (arready !== 1'b1);
    @(posedge core_clk_in);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge core_clk_in); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge core_clk_in);
    rready <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Lane words are driven, then given a fixed few edges to reach the receiver model.
  // The receiver words are read on the falling edge, away from the edge that launches them.
  task automatic chk_lanes(input logic [LW-1:0] e0, input logic [LW-1:0] e1);
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in);
    chk_val("lane0", 32'(e0), 32'(rx0));
    chk_val("lane1", 32'(e1), 32'(rx1));
    @(posedge core_clk_in);
  endtask

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    fails = 0; checked = 0; cycles = 0; rst_n_in = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = '0;
    dense = 1'b1; cwpf = 5'h0A; sfield = 5'h03; params = 64'h0102030405060708;
    ldata = {20'hD3333, 20'hC2222, 20'hB1111, 20'hA0000};
    repeat (4) @(posedge core_clk_in);
    chk_val("pd_rst", 32'h0, 32'(pdown));
    chk_val("swing_rst", 32'h9, {26'h0, swing1, swing0});
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    foreach (rst_rows[i]) begin
      axi_rd(rst_rows[i].idx, rv, resp);
      chk_val("reset_value", rst_rows[i].rd, rv);
    end
    chk_lanes(20'hA0000, 20'hB1111);
    foreach (rows[i]) begin
      axi_wr(rows[i].idx, rows[i].wd, resp);
      chk_resp("bresp", rows[i].wr, resp);
      axi_rd(rows[i].idx, rv, resp);
      chk_val("rdata", rows[i].rd, rv);
      chk_resp("rresp", rows[i].rr, resp);
    end
    chk_val("swing", 32'h07, {26'h0, swing1, swing0});
    chk_val("samples", 32'h4, 32'(spf));
    chk_lanes(20'hD3333, 20'hC2222);
    sum = 8'h24 + 8'h8A + 8'h03;
    axi_rd(IDX_CHK0, rv, resp);
    chk_val("checksum0", 32'(sum + 8'h03), rv);
    axi_rd(IDX_CHK1, rv, resp);
    chk_val("checksum1", 32'(sum + 8'h02), rv);
    axi_wr(IDX_PWR, 32'h000000FB, resp);
    chk_lanes(20'h0, 20'hC2222);
    chk_val("pdown", 32'h1, 32'(pdown));
    axi_wr(IDX_PWR, 32'h000000FE, resp);
    chk_lanes(20'hD3333, 20'h0);
    chk_val("pdown", 32'h2, 32'(pdown));
    axi_wr(IDX_PWR, 32'h000000FA, resp);
    axi_wr(IDX_SEL0, 32'h00000004, resp);
    chk_lanes(20'h0, 20'hC2222);
    axi_wr(IDX_SWING1, 32'h00000005, resp, 4'hE);
    chk_resp("bresp_nostrobe", RESP_OKAY, resp);
    chk_val("swing_nostrobe", 32'h07, {26'h0, swing1, swing0});
    complete_run();
  end
endmodule // testbench

// ===== core/jtl_lane_cfg.sv
// Lane configuration register slice of the link transmitter, with an AXI4-Lite slave port.
// Assumes link parameters and logical lane data come from logic on core_clk_in.
// Notes on behaviour
// - Dense packing flag reads at bit 7.
// - Control words per frame read at bits 4..0.
// - Lane 0 checksum is parameter sum plus lane 0 select, mod 256.
// - Lane 1 checksum computed independently, same way.
// - Power bit 0 forces physical lane 0 down.
// - Power bit 2 forces physical lane 1 down.
// - Lane 0 carries selected logical lane, default 0.
// - Lane 1 carries selected logical lane, default 1.
// - Lane 0 swing code drives its driver, reset 1.
// - Lane 1 swing code drives its driver, reset 1.
// - Samples per frame is field plus one.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
module jtl_lane_cfg #(
  parameter int LANE_W    = 20,
  parameter int NUM_PBYTE = 8
) (
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic [jtl_pkg::ADDR_W-1:0]    s_axi_awaddr_in,
  input  wire logic                          s_axi_awvalid_in,
  output logic                               s_axi_awready_out,
  input  wire logic [jtl_pkg::DATA_W-1:0]    s_axi_wdata_in,
  input  wire logic [3:0]                    s_axi_wstrb_in,
  input  wire logic                          s_axi_wvalid_in,
  output logic                               s_axi_wready_out,
  output logic [1:0]                         s_axi_bresp_out,
  output logic                               s_axi_bvalid_out,
  input  wire logic                          s_axi_bready_in,
  input  wire logic [jtl_pkg::ADDR_W-1:0]    s_axi_araddr_in,
  input  wire logic                          s_axi_arvalid_in,
  output logic                               s_axi_arready_out,
  output logic [jtl_pkg::DATA_W-1:0]         s_axi_rdata_out,
  output logic [1:0]                         s_axi_rresp_out,
  output logic                               s_axi_rvalid_out,
  input  wire logic                          s_axi_rready_in,
  input  wire logic                          dense_packing_flag_in,
  input  wire logic [jtl_pkg::CWPF_W-1:0]    ctrl_words_per_frame_in,
  input  wire logic [jtl_pkg::SAMP_W-1:0]    samples_field_in,
  input  wire logic [NUM_PBYTE*8-1:0]        link_params_in,
  input  wire logic [jtl_pkg::NUM_LOGIC*LANE_W-1:0] logical_lane_data_in,
  output logic [LANE_W-1:0]                  serial_out_lane0_out,
  output logic [LANE_W-1:0]                  serial_out_lane1_out,
  output logic [jtl_pkg::NUM_LANES-1:0]      lane_power_down_out,
  output logic [jtl_pkg::SWING_W-1:0]        lane0_swing_out,
  output logic [jtl_pkg::SWING_W-1:0]        lane1_swing_out,
  output logic [jtl_pkg::SAMP_W:0]           samples_per_frame_out
);
  import jtl_pkg::*;

  if (LANE_W < 1 || NUM_PBYTE < 1) begin : g_param_check
    $error("jtl_lane_cfg: LANE_W and NUM_PBYTE must be at least 1.");
  end

  // Bus state.
  logic                aw_hold_r, aw_hold_nxt;
  logic                w_hold_r, w_hold_nxt;
  logic [IDX_W-1:0]    aw_idx_r, aw_idx_nxt;
  logic [7:0]          w_data_r, w_data_nxt;
  logic                w_lo_r, w_lo_nxt;
  logic                bvalid_r, bvalid_nxt;
  logic [1:0]          bresp_r, bresp_nxt;
  logic                rvalid_r, rvalid_nxt;
  logic [1:0]          rresp_r, rresp_nxt;
  logic [DATA_W-1:0]   rdata_r, rdata_nxt;

  // Register state.
  jtl_byte_type        pwr_r, pwr_nxt;
  logic [SEL_W-1:0]    sel_r [NUM_LANES];
  logic [SEL_W-1:0]    sel_nxt [NUM_LANES];
  logic [2:0]          sel_rsv_r [NUM_LANES];
  logic [2:0]          sel_rsv_nxt [NUM_LANES];
  logic [SWING_W-1:0]  swing_r [NUM_LANES];
  logic [SWING_W-1:0]  swing_nxt [NUM_LANES];
  jtl_byte_type        chk_r [NUM_LANES];
  jtl_byte_type        chk_nxt [NUM_LANES];
  logic [LANE_W-1:0]   lane_r [NUM_LANES];
  logic [LANE_W-1:0]   lane_nxt [NUM_LANES];
  logic [SAMP_W:0]     samples_r, samples_nxt;

  logic                aw_take, w_take, ar_take, wr_fire;
  logic [IDX_W-1:0]    wr_idx, rd_idx;
  logic [7:0]          wr_byte;
  logic                wr_lo;
  logic [NUM_LANES-1:0] pd_bits;

  assign s_axi_awready_out = !aw_hold_r && !bvalid_r;
  assign s_axi_wready_out  = !w_hold_r && !bvalid_r;
  assign s_axi_arready_out = !rvalid_r;
  assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take  = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
  // Address and data may arrive in either order; the write fires in the cycle that both are held or being taken.
  assign wr_fire = (aw_hold_r || aw_take) && (w_hold_r || w_take);
  assign wr_idx  = aw_hold_r ? aw_idx_r : s_axi_awaddr_in[ADDR_W-1:2];
  assign wr_byte = w_hold_r ? w_data_r : s_axi_wdata_in[7:0];
  assign wr_lo   = w_hold_r ? w_lo_r : s_axi_wstrb_in[0];
  assign rd_idx  = s_axi_araddr_in[ADDR_W-1:2];
  assign pd_bits = {pwr_r[PD1_BIT], pwr_r[PD0_BIT]};

  function automatic logic mapped(input logic [IDX_W-1:0] idx);
    mapped = (idx == IDX_DENSITY) || (idx == IDX_SAMPLES) || (idx == IDX_CHK0)
          || (idx == IDX_CHK1) || (idx == IDX_PWR) || (idx == IDX_SEL0)
          || (idx == IDX_SEL1) || (idx == IDX_SWING0) || (idx == IDX_SWING1);
  endfunction

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    aw_idx_nxt  = aw_idx_r;
    w_data_nxt  = w_data_r;
    w_lo_nxt    = w_lo_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (aw_take) begin
      aw_hold_nxt = 1'b1;
      aw_idx_nxt  = s_axi_awaddr_in[ADDR_W-1:2];
    end
    if (w_take) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata_in[7:0];
      w_lo_nxt   = s_axi_wstrb_in[0];
    end
    if (s_axi_bvalid_out && s_axi_bready_in) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Register writes; read-only registers accept the write and keep their value.
  always_comb begin
    pwr_nxt     = pwr_r;
    sel_nxt     = sel_r;
    sel_rsv_nxt = sel_rsv_r;
    swing_nxt   = swing_r;
    if (wr_fire && wr_lo) begin
      unique case (wr_idx)
        IDX_PWR: pwr_nxt = wr_byte;
        IDX_SEL0: begin
          sel_nxt[0]     = wr_byte[SEL_W-1:0];
          sel_rsv_nxt[0] = wr_byte[SEL_RSV_LSB +: 3];
        end
        IDX_SEL1: begin
          sel_nxt[1]     = wr_byte[SEL_W-1:0];
          sel_rsv_nxt[1] = wr_byte[SEL_RSV_LSB +: 3];
        end
        IDX_SWING0: swing_nxt[0] = wr_byte[SWING_W-1:0];
        IDX_SWING1: swing_nxt[1] = wr_byte[SWING_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (s_axi_rvalid_out && s_axi_rready_in) begin
      rvalid_nxt = 1'b0;
    end
    if (ar_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      rdata_nxt  = '0;
      unique case (rd_idx)
        IDX_DENSITY: begin
          rdata_nxt[DENSE_BIT]            = dense_packing_flag_in;
          rdata_nxt[CWPF_LSB +: CWPF_W]   = ctrl_words_per_frame_in;
        end
        IDX_SAMPLES: rdata_nxt[SAMP_W-1:0] = samples_field_in;
        IDX_CHK0:    rdata_nxt[7:0] = chk_r[0];
        IDX_CHK1:    rdata_nxt[7:0] = chk_r[1];
        IDX_PWR:     rdata_nxt[7:0] = pwr_r;
        IDX_SEL0:    rdata_nxt[7:0] = {1'b0, sel_rsv_r[0], SEL0_FIX, sel_r[0]};
        IDX_SEL1:    rdata_nxt[7:0] = {1'b0, sel_rsv_r[1], SEL1_FIX, sel_r[1]};
        IDX_SWING0:  rdata_nxt[SWING_W-1:0] = swing_r[0];
        IDX_SWING1:  rdata_nxt[SWING_W-1:0] = swing_r[1];
        default:     rdata_nxt = '0;
      endcase
    end
  end

  // Sample count is one more than the field, so a field of zero means one sample.
  always_comb begin
    samples_nxt = {1'b0, samples_field_in} + 6'h01;
  end

  // Per physical lane: checksum, logical lane routing and forced power-down.
  // Codes above three select no logical lane and the output idles at zero.
  for (genvar ln = 0; ln < NUM_LANES; ln++) begin : g_lane
    always_comb begin
      jtl_byte_type acc;
      acc = 8'h00;
      for (int b = 0; b < NUM_PBYTE; b++) begin
        acc = acc + link_params_in[b*8 +: 8];
      end
      acc = acc + {dense_packing_flag_in, 2'h0, ctrl_words_per_frame_in};
      acc = acc + {3'h0, samples_field_in};
      acc = acc + {5'h00, sel_r[ln]};
      chk_nxt[ln] = acc;
      lane_nxt[ln] = '0;
      if (!pd_bits[ln] && sel_r[ln] < 3'(NUM_LOGIC)) begin
        lane_nxt[ln] = logical_lane_data_in[sel_r[ln][1:0]*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_idx_r  <= '0;
      w_data_r  <= 8'h00;
      w_lo_r    <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
      pwr_r     <= PWR_RST;
      sel_r[0]  <= SEL0_RST;
      sel_r[1]  <= SEL1_RST;
      sel_rsv_r[0] <= SEL0_RSV_RST;
      sel_rsv_r[1] <= SEL1_RSV_RST;
      swing_r[0] <= SWING_RST;
      swing_r[1] <= SWING_RST;
      chk_r[0]  <= CHK0_RST;
      chk_r[1]  <= CHK1_RST;
      lane_r[0] <= '0;
      lane_r[1] <= '0;
      samples_r <= '0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      aw_idx_r  <= aw_idx_nxt;
      w_data_r  <= w_data_nxt;
      w_lo_r    <= w_lo_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      pwr_r     <= pwr_nxt;
      sel_r     <= sel_nxt;
      sel_rsv_r <= sel_rsv_nxt;
      swing_r   <= swing_nxt;
      chk_r     <= chk_nxt;
      lane_r    <= lane_nxt;
      samples_r <= samples_nxt;
    end
  end

  assign s_axi_bvalid_out      = bvalid_r;
  assign s_axi_bresp_out       = bresp_r;
  assign s_axi_rvalid_out      = rvalid_r;
  assign s_axi_rresp_out       = rresp_r;
  assign s_axi_rdata_out       = rdata_r;
  assign serial_out_lane0_out  = lane_r[0];
  assign serial_out_lane1_out  = lane_r[1];
  assign lane_power_down_out   = pd_bits;
  assign lane0_swing_out       = swing_r[0];
  assign lane1_swing_out       = swing_r[1];
  assign samples_per_frame_out = samples_r;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_DENSE_READ: assert property (
    ar_take && rd_idx == IDX_DENSITY |=>
      s_axi_rvalid_out && s_axi_rdata_out[DENSE_BIT] == $past(dense_packing_flag_in)
      && s_axi_rdata_out[6:5] == 2'h0)
    else $error("Dense packing flag read wrong.");
  AST_CWPF_READ: assert property (
    ar_take && rd_idx == IDX_DENSITY |=>
      s_axi_rdata_out[CWPF_LSB +: CWPF_W] == $past(ctrl_words_per_frame_in))
    else $error("Control words per frame read wrong.");
  AST_CHK_LANE_DIFF: assert property (
    $stable(link_params_in) && $stable(samples_field_in) && $stable(ctrl_words_per_frame_in)
    && $stable(dense_packing_flag_in) && $stable(sel_r[0]) && $stable(sel_r[1])
    |=> 8'(chk_r[1] - chk_r[0])
      == 8'({5'h00, $past(sel_r[1])} - {5'h00, $past(sel_r[0])}))
    else $error("Lane checksums disagree with lane selection.");
  AST_CHK1_TRACK: assert property (
    $changed(sel_r[1]) && $stable(link_params_in) |=>
      8'(chk_r[1] - $past(chk_r[1])) == 8'({5'h00, $past(sel_r[1])} - {5'h00, $past(sel_r[1], 2)}))
    else $error("Lane 1 checksum did not follow its parameters.");
  AST_PD0_IDLE: assert property (
    pwr_r[PD0_BIT] |-> lane_power_down_out[0] ##1 serial_out_lane0_out == '0)
    else $error("Lane 0 not idle while powered down.");
  AST_PD1_IDLE: assert property (
    pwr_r[PD1_BIT] |-> lane_power_down_out[1] ##1 serial_out_lane1_out == '0)
    else $error("Lane 1 not idle while powered down.");
  AST_LANE0_ROUTE: assert property (
    !pwr_r[PD0_BIT] && sel_r[0] < 3'h4 |=>
      serial_out_lane0_out == $past(logical_lane_data_in[sel_r[0][1:0]*LANE_W +: LANE_W]))
    else $error("Lane 0 carries the wrong logical lane.");
  AST_LANE1_ROUTE: assert property (
    !pwr_r[PD1_BIT] && sel_r[1] < 3'h4 |=>
      serial_out_lane1_out == $past(logical_lane_data_in[sel_r[1][1:0]*LANE_W +: LANE_W]))
    else $error("Lane 1 carries the wrong logical lane.");
  AST_SWING0_WRITE: assert property (
    wr_fire && wr_lo && wr_idx == IDX_SWING0 |=>
      lane0_swing_out == $past(wr_byte[SWING_W-1:0]) && s_axi_bvalid_out)
    else $error("Lane 0 swing code not applied.");
  AST_SWING1_WRITE: assert property (
    wr_fire && wr_lo && wr_idx == IDX_SWING1 |=>
      lane1_swing_out == $past(wr_byte[SWING_W-1:0]) ##1 lane1_swing_out == $past(lane1_swing_out)
      || wr_fire)
    else $error("Lane 1 swing code not applied.");
  AST_SAMPLES: assert property (
    $stable(samples_field_in) |=>
      samples_per_frame_out == {1'b0, $past(samples_field_in)} + 6'h01)
    else $error("Samples per frame is not field plus one.");
  AST_BVALID_HOLD: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("Write response dropped before it was taken.");

  COV_SPLIT_WRITE: cover property (aw_take && !w_take ##[1:4] w_take);
  COV_PD_LANE1: cover property (wr_fire && wr_idx == IDX_PWR && wr_byte[PD1_BIT]);
  COV_BAD_READ: cover property (ar_take && !mapped(rd_idx));
  COV_REMAP: cover property (wr_fire && wr_idx == IDX_SEL0 && wr_byte[2:0] == 3'h3);

endmodule // jtl_lane_cfg

// ===== core/jtl_pkg.sv
// Constants for the link transmitter lane configuration register slice.
// Assumes an AXI4-Lite master with 32-bit data; each register index sits at byte index*4.
package jtl_pkg;

  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 32;
  localparam int IDX_W     = ADDR_W - 2;
  localparam int NUM_LANES = 2;
  localparam int NUM_LOGIC = 4;

  typedef logic [7:0] jtl_byte_type;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_DENSITY = 14'h0592;
  localparam logic [IDX_W-1:0] IDX_SAMPLES = 14'h0591;
  localparam logic [IDX_W-1:0] IDX_CHK0    = 14'h05A0;
  localparam logic [IDX_W-1:0] IDX_CHK1    = 14'h05A1;
  localparam logic [IDX_W-1:0] IDX_PWR     = 14'h05B0;
  localparam logic [IDX_W-1:0] IDX_SEL0    = 14'h05B2;
  localparam logic [IDX_W-1:0] IDX_SEL1    = 14'h05B3;
  localparam logic [IDX_W-1:0] IDX_SWING0  = 14'h05C0;
  localparam logic [IDX_W-1:0] IDX_SWING1  = 14'h05C1;

  // Field positions.
  localparam int DENSE_BIT  = 7;
  localparam int CWPF_LSB   = 0;
  localparam int CWPF_W     = 5;
  localparam int SAMP_W     = 5;
  localparam int PD0_BIT    = 0;
  localparam int PD1_BIT    = 2;
  localparam int SEL_W      = 3;
  localparam int SEL_RSV_LSB = 4;
  localparam int SEL_FIX_BIT = 3;
  localparam int SWING_W    = 3;

  // Reset values.
  localparam jtl_byte_type     CHK0_RST     = 8'hC3;
  localparam jtl_byte_type     CHK1_RST     = 8'hC4;
  localparam jtl_byte_type     PWR_RST      = 8'hFA;
  localparam logic [SEL_W-1:0] SEL0_RST     = 3'h0;
  localparam logic [SEL_W-1:0] SEL1_RST     = 3'h1;
  localparam logic [2:0]       SEL0_RSV_RST = 3'h0;
  localparam logic [2:0]       SEL1_RSV_RST = 3'h1;
  localparam logic             SEL0_FIX     = 1'h0;
  localparam logic             SEL1_FIX     = 1'h1;
  localparam logic [SWING_W-1:0] SWING_RST  = 3'h1;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
